// File: verilog/eeprom_map.svh
/*
  Constants of the two-wire EEPROM link: timing counts, address layout,
  controller register map and command fields.
  Assumes pclk at 20 MHz and inclusion by the device, the controller and the checker.
*/
// Function
// - memory is 16-byte rows, page within one
// - master streams bytes, device acks each one
// - stop after data starts timed programming, 5 ms
// - column bits count up, row bits stay
// - page write may start at any column
// - beyond 16 bytes the column wraps over
// - no address ack while programming
// - direction bit 1 reads, 0 writes
// - address counter keeps last location plus one
// - current read acks, sends byte, counts up
// - master nack then stop ends read
// - master ack fetches next sequential byte
// - read counter wraps from top to zero
// - random read is dummy write then read
// - new start cancels pending write
// - ignore bus while held in reset
// - master waits 100 us before commands
// - device address starts with 1010 pattern
// - device acks by pulling data low
// - word address is one 8-bit byte
// - write protect high blocks programming
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH
`define EE_CLK_NS        50
`define EE_PROG_MS       5
`define EE_PROG_CYCLES   (`EE_PROG_MS * 1000000 / `EE_CLK_NS)
`define EE_PUP_US        100
`define EE_PUP_CYCLES    16'((`EE_PUP_US * 1000 + `EE_CLK_NS - 1) / `EE_CLK_NS)
`define EE_QTR_CYCLES    2'h2
`define EE_ROW_BYTES     16
`define EE_DEV_CODE      4'hA
`define EE_LAST_BIT      4'h7
`define EE_ACK_BIT       4'h8
`define EE_REG_CMD       8'h00
`define EE_REG_STAT      8'h04
`define EE_REG_RX        8'h08
`define EE_CMD_START     8
`define EE_CMD_STOP      9
`define EE_CMD_READ      10
`define EE_CMD_NACK      11
`define EE_STAT_BUSY     0
`define EE_STAT_ACK      1
`define EE_STAT_READY    2
`endif

// File: verilog/eeprom_pkg.sv
/*
  Types shared by both ends of the two-wire EEPROM link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package eeprom_pkg;
  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_dev   = 3'b001,
    st_word  = 3'b010,
    st_wdata = 3'b011,
    st_read  = 3'b100
  } dev_state_e;
  typedef enum logic [2:0] {
    m_idle  = 3'b000,
    m_start = 3'b001,
    m_bits  = 3'b010,
    m_tail  = 3'b011,
    m_stop  = 3'b100
  } mst_state_e;
endpackage

// File: verilog/twi_if.sv
/*
  Two-wire bus between controller and EEPROM.
  Assumes pull-ups: a line is low only while some end enables a low drive.
*/
`timescale 1ns/1ns
interface twi_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;
  // wired-and with pull-up
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);
  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport dev (output d_sda_o, d_sda_oe, input scl, sda);
endinterface

// File: verilog/eeprom_dev.sv
/*
  Target end: 256-byte EEPROM with page write, polling and three reads.
  Assumes presetn acts as power-on reset and the bus pins are asynchronous.
*/
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "eeprom_map.svh"
module eeprom_dev #(
  parameter int unsigned PROG_CYCLES = `EE_PROG_CYCLES
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] chip_select_pins,
  input  wire logic       write_protect,
  output logic            programming,
  twi_if.dev              bus
);
  eeprom_pkg::dev_state_e state;
  logic [7:0]  mem [0:255];
  logic [7:0]  page_buf [0:`EE_ROW_BYTES-1];
  logic [15:0] page_vld;
  logic [2:0]  scl_s;
  logic [2:0]  sda_s;
  logic [1:0]  wp_s;
  logic [5:0]  cs_s;
  logic [3:0]  cnt;
  logic [7:0]  shreg;
  logic [7:0]  tx;
  logic [7:0]  addr;
  logic [3:0]  prog_row;
  logic        ack_en;
  logic        written;
  logic [31:0] timer;
  logic        sda_oe;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        byte_ev;
  logic        prog_go;
  logic        prog_done;
  logic [7:0]  rx_byte;
  logic        addr_match;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, edges, start and stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      wp_s  <= 2'h0;
      cs_s  <= 6'h00;
    end else begin
      scl_s <= {scl_s[1:0], bus.scl};
      sda_s <= {sda_s[1:0], bus.sda};
      wp_s  <= {wp_s[0], write_protect};
      cs_s  <= {cs_s[2:0], chip_select_pins};
    end
  end

  assign scl_rise  = scl_s[1] & ~scl_s[2];
  assign scl_fall  = ~scl_s[1] & scl_s[2];
  assign start_det = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop_det  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
  assign rx_byte   = {shreg[6:0], sda_s[1]};
  assign byte_ev   = scl_rise && cnt == `EE_LAST_BIT && state != eeprom_pkg::st_read;
  assign addr_match = rx_byte[7:4] == `EE_DEV_CODE && rx_byte[3:1] == cs_s[5:3];
  assign prog_go   = stop_det && state == eeprom_pkg::st_wdata && written && !wp_s[1];
  assign prog_done = programming && timer == PROG_CYCLES - 1;

  ////////////////////////////////////////////////////////////////////////
  // protocol sequencer
  // reset holds sequencer idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= eeprom_pkg::st_idle;
      cnt     <= 4'h0;
      shreg   <= 8'h00;
      tx      <= 8'hFF;
      addr    <= 8'h00;
      ack_en  <= 1'b0;
      written <= 1'b0;
    end else if (start_det) begin
      state   <= eeprom_pkg::st_dev;
      cnt     <= 4'h0;
      ack_en  <= 1'b0;
      written <= 1'b0;
    end else if (stop_det) begin
      state  <= eeprom_pkg::st_idle;
      ack_en <= 1'b0;
    end else if (scl_rise && state != eeprom_pkg::st_idle) begin
      if (cnt == `EE_ACK_BIT) begin
        cnt    <= 4'h0;
        ack_en <= 1'b0;
        if (state == eeprom_pkg::st_read) begin
          if (!sda_s[1]) begin
            tx   <= mem[addr];
            addr <= addr + 8'h01;
          end else begin
            state <= eeprom_pkg::st_idle;
          end
        end
      end else begin
        cnt   <= cnt + 4'h1;
        shreg <= rx_byte;
        if (state == eeprom_pkg::st_read) begin
          tx <= {tx[6:0], 1'b1};
        end
        if (byte_ev) begin
          case (state)
            eeprom_pkg::st_dev: begin
              // no ack while busy, direction bit
              if (addr_match && !programming) begin
                ack_en <= 1'b1;
                state  <= rx_byte[0] ? eeprom_pkg::st_read : eeprom_pkg::st_word;
              end else begin
                state <= eeprom_pkg::st_idle;
              end
            end
            eeprom_pkg::st_word: begin
              addr   <= rx_byte;
              ack_en <= 1'b1;
              state  <= eeprom_pkg::st_wdata;
            end
            eeprom_pkg::st_wdata: begin
              addr    <= {addr[7:4], addr[3:0] + 4'h1};
              ack_en  <= 1'b1;
              written <= 1'b1;
            end
            default: state <= eeprom_pkg::st_idle;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // page buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_vld <= 16'h0000;
    end else if (byte_ev && state == eeprom_pkg::st_word) begin
      page_vld <= 16'h0000;
    end else if (byte_ev && state == eeprom_pkg::st_wdata) begin
      page_vld[addr[3:0]] <= 1'b1;
    end
  end

  always_ff @(posedge pclk) begin
    if (byte_ev && state == eeprom_pkg::st_wdata) begin
      page_buf[addr[3:0]] <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self-timed programming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      programming <= 1'b0;
      timer       <= 32'h0;
      prog_row    <= 4'h0;
    end else if (prog_go && !programming) begin
      programming <= 1'b1;
      timer       <= 32'h0;
      prog_row    <= addr[7:4];
    end else if (prog_done) begin
      programming <= 1'b0;
    end else if (programming) begin
      timer <= timer + 32'h1;
    end
  end

  always_ff @(posedge pclk) begin
    if (prog_done) begin
      for (int i = 0; i < `EE_ROW_BYTES; i++) begin
        if (page_vld[i]) begin
          mem[{prog_row, 4'(i)}] <= page_buf[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data line drive, low only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_oe <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      if (cnt == `EE_ACK_BIT) begin
        sda_oe <= ack_en;
      end else if (state == eeprom_pkg::st_read) begin
        sda_oe <= ~tx[7];
      end else begin
        sda_oe <= 1'b0;
      end
    end
  end

  assign bus.d_sda_oe = sda_oe;
  assign bus.d_sda_o  = 1'b0;
endmodule

// File: verilog/twi_master.sv
/*
  Controller end: APB registers drive byte transfers on the two-wire bus.
  Assumes pclk at 20 MHz and a bus level fed back through the interface.
*/
`timescale 1ns/1ns
`include "eeprom_map.svh"
module twi_master (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  twi_if.master            bus
);
  eeprom_pkg::mst_state_e state;
  logic [15:0] pup_cnt;
  logic        ready;
  logic [1:0]  div;
  logic [1:0]  q;
  logic [3:0]  bitn;
  logic [8:0]  txs;
  logic [8:0]  rxs;
  logic        do_stop;
  logic        is_read;
  logic        scl_oe;
  logic        sda_oe;
  logic [1:0]  sda_s;
  logic        tick;
  logic        wr_ok;
  logic        cmd_go;

  assign tick   = div == `EE_QTR_CYCLES - 2'h1;
  assign wr_ok  = psel && penable && pready && pwrite;
  assign cmd_go = wr_ok && paddr == `EE_REG_CMD && ready && state == eeprom_pkg::m_idle;

  ////////////////////////////////////////////////////////////////////////
  // apb slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && paddr != `EE_REG_CMD
                 && paddr != `EE_REG_STAT && paddr != `EE_REG_RX;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          `EE_REG_STAT: prdata <= {29'h0, ready, ~rxs[0], state != eeprom_pkg::m_idle};
          `EE_REG_RX:   prdata <= {24'h0, rxs[8:1]};
          default:      prdata <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-up wait and quarter-bit divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pup_cnt <= 16'h0;
      ready   <= 1'b0;
      div     <= 2'h0;
      sda_s   <= 2'h3;
    end else begin
      if (pup_cnt == `EE_PUP_CYCLES - 16'h1) begin
        ready <= 1'b1;
      end else begin
        pup_cnt <= pup_cnt + 16'h1;
      end
      div   <= tick ? 2'h0 : div + 2'h1;
      sda_s <= {sda_s[0], bus.sda};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= eeprom_pkg::m_idle;
      q       <= 2'h0;
      bitn    <= 4'h0;
      txs     <= 9'h1FF;
      rxs     <= 9'h1FF;
      do_stop <= 1'b0;
      is_read <= 1'b0;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (cmd_go) begin
      do_stop <= pwdata[`EE_CMD_STOP];
      is_read <= pwdata[`EE_CMD_READ];
      // read releases data, acks or not
      txs     <= pwdata[`EE_CMD_READ] ? {8'hFF, pwdata[`EE_CMD_NACK]} : {pwdata[7:0], 1'b1};
      bitn    <= 4'h0;
      q       <= 2'h0;
      state   <= pwdata[`EE_CMD_START] ? eeprom_pkg::m_start : eeprom_pkg::m_bits;
    end else if (tick && state != eeprom_pkg::m_idle) begin
      q <= q + 2'h1;
      case (state)
        eeprom_pkg::m_start: begin
          case (q)
            2'h0: sda_oe <= 1'b0;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b1;
            default: begin
              scl_oe <= 1'b1;
              state  <= eeprom_pkg::m_bits;
            end
          endcase
        end
        eeprom_pkg::m_bits: begin
          case (q)
            2'h0: scl_oe <= 1'b1;
            2'h1: sda_oe <= ~txs[8];
            2'h2: scl_oe <= 1'b0;
            default: begin
              rxs  <= {rxs[7:0], sda_s[1]};
              txs  <= {txs[7:0], 1'b1};
              bitn <= bitn + 4'h1;
              if (bitn == `EE_ACK_BIT) begin
                state <= do_stop ? eeprom_pkg::m_stop : eeprom_pkg::m_tail;
              end
            end
          endcase
        end
        eeprom_pkg::m_tail: begin
          scl_oe <= 1'b1;
          state  <= eeprom_pkg::m_idle;
        end
        eeprom_pkg::m_stop: begin
          case (q)
            2'h0: scl_oe <= 1'b1;
            2'h1: sda_oe <= 1'b1;
            2'h2: scl_oe <= 1'b0;
            default: begin
              sda_oe <= 1'b0;
              state  <= eeprom_pkg::m_idle;
            end
          endcase
        end
        default: state <= eeprom_pkg::m_idle;
      endcase
    end
  end

  assign bus.m_scl_oe = scl_oe;
  assign bus.m_scl_o  = 1'b0;
  assign bus.m_sda_oe = sda_oe;
  assign bus.m_sda_o  = 1'b0;
endmodule

// File: sim/link_checker.sv
/*
  assertions on the two-wire link and the write timer
  assumes link signals and programming flag in the pclk domain
*/
`timescale 1ns/1ns
`include "eeprom_map.svh"
module link_checker #(
  parameter int unsigned PROG_CYCLES = `EE_PROG_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic programming,
  input wire logic write_protect
);
  logic        scl_q;
  logic        sda_q;
  logic        first;
  logic        rd;
  logic [3:0]  bitn;
  logic [5:0]  since;
  logic [31:0] cnt;
  wire         stop_c = scl && scl_q && !sda_q && sda;
  wire         start_c = scl && scl_q && sda_q && !sda;
  wire         rise_c = scl && !scl_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  // line history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // bit position within a byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bitn <= 4'h0;
      first <= 1'b0;
    end else if (start_c) begin
      bitn <= 4'h0;
      first <= 1'b1;
    end else if (rise_c) begin
      bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
      first <= first && (bitn != 4'h8);
    end
  end
  // direction bit of the address byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rd <= 1'b0;
    else if (rise_c && first && bitn == 4'h7) rd <= sda;
  end
  // cycles since stop, cycles programming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since <= 6'h3F;
    else if (stop_c) since <= 6'h00;
    else if (since != 6'h3F) since <= since + 6'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 32'h0;
    else cnt <= programming ? cnt + 32'h1 : 32'h0;
  end
  ////////////////////////////////////////////////////////////
  sequence stop_s;
    stop_c;
  endsequence
  sequence quiet_s;
    !d_sda_oe [*8];
  endsequence
  drive_low_a: assert property (d_sda_oe |-> !d_sda_o && !sda)
    else $error("device drives data high");
  prog_quiet_a: assert property (programming |-> !d_sda_oe)
    else $error("device answers while programming");
  prog_len_a: assert property ($fell(programming) |->
    cnt <= PROG_CYCLES && cnt + 2 >= PROG_CYCLES) else $error("write time wrong");
  prog_cause_a: assert property ($rose(programming) |-> since < 6'd12)
    else $error("programming without stop");
  wp_block_a: assert property (write_protect && $past(write_protect, 4)
    |-> !$rose(programming)) else $error("programming while protected");
  reset_idle_a: assert property ($rose(presetn) |-> !d_sda_oe && !programming)
    else $error("device active after reset");
  sda_edge_a: assert property ($changed(d_sda_oe) |-> !$past(scl, 3))
    else $error("data changed with clock high");
  ack_slot_a: assert property (rise_c && d_sda_oe && (first || !rd)
    |-> bitn == 4'h8) else $error("device drives outside ack slot");
  stop_free_a: assert property (stop_s |-> ##1 quiet_s)
    else $error("device drives after stop");
endmodule

// File: sim/serial_eeprom_page_write_and_read_bench.sv
/*
  self-checking bench: controller and EEPROM joined by the link
  assumes the design files and the checker are compiled first
*/
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module serial_eeprom_page_write_and_read_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        write_protect = 1'b0;
  logic        programming;
  logic [31:0] st;
  logic        err;
  int          fails = 0;
  int          checked = 0;
  int          cyc = 0;
  twi_if link();
  twi_master twi_master_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(link));
  eeprom_dev #(.PROG_CYCLES(400)) eeprom_dev_i(.pclk(pclk), .presetn(presetn),
    .chip_select_pins(3'b101), .write_protect(write_protect),
    .programming(programming), .bus(link));
  link_checker #(.PROG_CYCLES(400)) link_checker_i(.pclk(pclk), .presetn(presetn),
    .scl(link.scl), .sda(link.sda), .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe),
    .programming(programming), .write_protect(write_protect));
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    st = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cmd(input logic [11:0] c, input logic ack);
    apb(1'b1, 8'h00, {20'h0, c});
    do apb(1'b0, 8'h04, 32'h0); while (st[0] === 1'b1);
    `CHK(st[1], ack)
  endtask
  task automatic get(input logic last, input logic [7:0] exp);
    cmd({last, 1'b1, last, 9'h000}, !last);
    apb(1'b0, 8'h08, 32'h0);
    `CHK(st[7:0], exp)
  endtask
  task automatic seek(input logic [7:0] a);
    cmd(12'h1AA, 1'b1);
    cmd({4'h0, a}, 1'b1);
    cmd(12'h1AB, 1'b1);
  endtask
  task automatic settle;
    repeat (8) @(posedge pclk);
    while (programming === 1'b1) @(posedge pclk);
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    cmd(12'h1AA, 1'b1);
    cmd({4'h0, a}, 1'b1);
    cmd({4'h2, d}, 1'b1);
    settle();
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_power;
    int t0;
    t0 = cyc;
    apb(1'b0, 8'h04, 32'h0);
    `CHK(st[2], 1'b0)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK({err, st}, 33'h100000000)
    do apb(1'b0, 8'h04, 32'h0); while (st[2] !== 1'b1);
    `CHK(cyc - t0 >= 1998, 1'b1)
    $display("power-up wait done");
  endtask
  task automatic t_page;
    cmd(12'h1AA, 1'b1);
    cmd(12'h03E, 1'b1);
    for (int k = 0; k < 18; k++) cmd({2'b00, k == 17, 1'b0, 8'h40 + 8'(k)}, 1'b1);
    repeat (8) @(posedge pclk);
    `CHK(programming, 1'b1)
    cmd(12'h3AA, 1'b0);
    cmd(12'h3AB, 1'b0);
    settle();
    cmd(12'h3AA, 1'b1);
    $display("page write done");
  endtask
  task automatic t_seq;
    seek(8'h30);
    for (int c = 0; c < 15; c++) get(c == 14, 8'h42 + 8'(c));
    cmd(12'h1AB, 1'b1);
    get(1'b1, 8'h51);
    $display("sequential read done");
  endtask
  task automatic t_wrap;
    put(8'hFF, 8'hC3);
    put(8'h00, 8'h3C);
    seek(8'hFF);
    get(1'b0, 8'hC3);
    get(1'b1, 8'h3C);
    $display("top wrap done");
  endtask
  task automatic t_cancel;
    cmd(12'h1AA, 1'b1);
    cmd(12'h03F, 1'b1);
    cmd(12'h099, 1'b1);
    cmd(12'h1AB, 1'b1);
    `CHK(programming, 1'b0)
    get(1'b1, 8'h42);
    seek(8'h3F);
    get(1'b1, 8'h51);
    $display("cancel done");
  endtask
  task automatic t_wp;
    write_protect <= 1'b1;
    put(8'h00, 8'h77);
    seek(8'h00);
    get(1'b1, 8'h3C);
    write_protect <= 1'b0;
    cmd(12'h3A2, 1'b0);
    cmd(12'h32A, 1'b0);
    $display("protect and address done");
  endtask
  task automatic t_reset;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK(link.sda, 1'b1)
    presetn <= 1'b1;
    @(posedge pclk);
    t_power();
    cmd(12'h1AB, 1'b1);
    get(1'b1, 8'h3C);
    $display("second reset done");
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_power();
    t_page();
    t_seq();
    t_wrap();
    t_cancel();
    t_wp();
    t_reset();
    test_done();
  end
endmodule
